// ==== rtl/down_counter_consts.svh ====
/*
 * Constants for the preset down counter: widths, count limits, reset values
 * and synchroniser depth.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef DOWN_COUNTER_CONSTS_SVH
`define DOWN_COUNTER_CONSTS_SVH

// ****************************************************************
// Counter geometry
// ****************************************************************
`define CNT_WIDTH        8
`define CNT_MAX          8'hff
`define CNT_ZERO         8'h00
`define CNT_ONE          8'h01
`define CNT_RESET_VAL    8'hff
`define CNT_PERIOD       256

// ****************************************************************
// Pin synchronisers
// ****************************************************************
`define SYNC_STAGES      2
`define CTRL_IDLE        4'hf
`define PRESET_RESET_VAL 8'h00

`endif

// ==== rtl/down_counter_pkg.sv ====
/*
 * Types shared by the preset down counter: the control pin group and the
 * decoded action applied to the count.
 * Assumes down_counter_consts.svh is on the include path.
 */
package down_counter_pkg;

`include "down_counter_consts.svh"

    typedef logic [`CNT_WIDTH-1:0] count_t;

    // Active-low control pins, highest precedence first.
    typedef struct packed {
        logic max_reset_n;
        logic async_load_n;
        logic sync_load_n;
        logic count_enable_n;
    } ctrl_s;

    // Gray-coded along hold, count, sync load, async load, clear.
    typedef enum logic [2:0] {
        ACT_HOLD       = 3'h0,
        ACT_COUNT      = 3'h1,
        ACT_SYNC_LOAD  = 3'h3,
        ACT_ASYNC_LOAD = 3'h2,
        ACT_CLEAR      = 3'h6
    } action_e;

endpackage

// ==== rtl/pin_sync.sv ====
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes its inputs are asynchronous to clk; the first stage feeds only
 * the second.
 */
module pin_sync
    import down_counter_pkg::*;
#(
    parameter int             WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q   <= RESET_VAL;
            stable_q <= RESET_VAL;
        end else begin
            meta_q   <= pin_in;
            stable_q <= meta_q;
        end
    end

    assign pin_sync_out = stable_q;

endmodule

// ==== rtl/preset_down_counter.sv ====
/*
 * Eight-bit preset down counter with clear to maximum, synchronous and
 * asynchronous preset, count enable and a terminal-count flag.
 * Assumes all pins, the count clock among them, come from board logic
 * outside the clk domain; each passes two flip-flops before use.
 */
`include "down_counter_consts.svh"

module preset_down_counter
    import down_counter_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  count_clock,
    input  wire logic                  count_enable_n,
    input  wire logic                  sync_load_n,
    input  wire logic                  async_load_n,
    input  wire logic                  max_reset_n,
    input  wire logic [`CNT_WIDTH-1:0] preset_value,
    output logic                       zero_flag_n,
    output logic      [`CNT_WIDTH-1:0] count_value
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************

    ctrl_s   ctrl_pins;
    ctrl_s   ctrl;
    count_t  preset_s;
    logic    count_clock_s;
    logic    count_clock_prev_q;
    logic    count_edge;
    count_t  count_q;
    count_t  count_d;
    action_e action;

    assign ctrl_pins = '{max_reset_n:    max_reset_n,
                         async_load_n:   async_load_n,
                         sync_load_n:    sync_load_n,
                         count_enable_n: count_enable_n};

    pin_sync #(
        .WIDTH     ($bits(ctrl_s)),
        .RESET_VAL (`CTRL_IDLE)
    ) u_ctrl_sync (
        .clk          (clk),
        .reset_n      (reset_n),
        .pin_in       (ctrl_pins),
        .pin_sync_out (ctrl)
    );

    pin_sync #(
        .WIDTH     (`CNT_WIDTH),
        .RESET_VAL (`PRESET_RESET_VAL)
    ) u_preset_sync (
        .clk          (clk),
        .reset_n      (reset_n),
        .pin_in       (preset_value),
        .pin_sync_out (preset_s)
    );

    pin_sync #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_clock_sync (
        .clk          (clk),
        .reset_n      (reset_n),
        .pin_in       (count_clock),
        .pin_sync_out (count_clock_s)
    );

    // ****************************************************************
    // Count clock edge detection
    // ****************************************************************

    // The previous level is taken from the synchronised copy only, so the
    // edge pulse is one clk cycle wide per rising count clock transition.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_clock_prev_q <= 1'b0;
        end else begin
            count_clock_prev_q <= count_clock_s;
        end
    end

    assign count_edge = count_clock_s && !count_clock_prev_q;

    // ****************************************************************
    // Action decode
    // ****************************************************************

    // Clear and async load act on every clk cycle, without waiting for a
    // count clock edge; the other actions wait for that edge.
    always_comb begin
        if (!ctrl.max_reset_n) begin
            action = ACT_CLEAR;
        end else if (!ctrl.async_load_n) begin
            action = ACT_ASYNC_LOAD;
        end else if (!count_edge) begin
            action = ACT_HOLD;
        end else if (!ctrl.sync_load_n) begin
            action = ACT_SYNC_LOAD;
        end else if (!ctrl.count_enable_n) begin
            action = ACT_COUNT;
        end else begin
            action = ACT_HOLD;
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************

    always_comb begin
        case (action)
            ACT_CLEAR:      count_d = `CNT_MAX;
            ACT_ASYNC_LOAD: count_d = preset_s;
            ACT_SYNC_LOAD:  count_d = preset_s;
            // Zero minus one wraps to the maximum count.
            ACT_COUNT:      count_d = count_q - `CNT_ONE;
            ACT_HOLD:       count_d = count_q;
            default:        count_d = count_q;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_q <= `CNT_RESET_VAL;
        end else begin
            count_q <= count_d;
        end
    end

    assign count_value = count_q;

    // ****************************************************************
    // Terminal count flag
    // ****************************************************************

    // Decoded without a flop so that it follows clears and loads directly
    // and a chained stage sees it before the next count clock edge.
    assign zero_flag_n = !((count_q == `CNT_ZERO) && !ctrl.count_enable_n);

    // ****************************************************************
    // Assertions
    // ****************************************************************

    sequence run_s;
        ctrl.max_reset_n && ctrl.async_load_n && ctrl.sync_load_n;
    endsequence

    clear_force_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        !ctrl.max_reset_n |=> (count_q == `CNT_MAX) && zero_flag_n
    ) else $error("clear did not force count to maximum");

    clear_priority_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!ctrl.max_reset_n && !ctrl.async_load_n && count_edge
            && preset_s != `CNT_MAX) |=> count_q == `CNT_MAX
    ) else $error("clear lost against another control");

    async_load_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ctrl.max_reset_n && !ctrl.async_load_n) |=> count_q == $past(preset_s)
    ) else $error("async load did not take preset word");

    async_no_edge_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ctrl.max_reset_n && !ctrl.async_load_n && !count_edge)[*2]
            |=> count_q == $past(preset_s)
    ) else $error("async load waited for a count clock edge");

    sync_load_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ctrl.max_reset_n && ctrl.async_load_n && !ctrl.sync_load_n
            && count_edge) |=> count_q == $past(preset_s)
    ) else $error("sync load did not take preset word on edge");

    sync_waits_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ctrl.max_reset_n && ctrl.async_load_n && !count_edge)
            |=> count_q == $past(count_q)
    ) else $error("count changed without a count clock edge");

    count_down_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (run_s and (count_edge && !ctrl.count_enable_n && count_q != `CNT_ZERO))
            |=> count_q == $past(count_q) - `CNT_ONE
    ) else $error("count did not step down by one");

    hold_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (run_s and ctrl.count_enable_n) |=> $stable(count_q)
    ) else $error("count moved while enable inactive");

    wrap_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (run_s and (count_edge && !ctrl.count_enable_n && count_q == `CNT_ZERO))
            |=> count_q == `CNT_MAX
    ) else $error("count did not wrap from zero to maximum");

    flag_zero_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        zero_flag_n == !((count_q == `CNT_ZERO) && !$past(count_enable_n, 2))
    ) else $error("zero flag disagrees with count and enable");

    flag_follow_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ctrl.max_reset_n && !ctrl.async_load_n && !ctrl.count_enable_n
            && preset_s == `CNT_ZERO)
            |=> (count_q == `CNT_ZERO) && (zero_flag_n == ctrl.count_enable_n)
    ) else $error("zero flag missed an async load of zero");

    flag_period_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ($rose(zero_flag_n) && ctrl.max_reset_n && ctrl.async_load_n
            && !ctrl.count_enable_n && $past(!ctrl.count_enable_n))
            |-> $past(count_edge)
    ) else $error("zero flag released between count clock edges");

    flag_low_hold_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!zero_flag_n && ctrl.max_reset_n && ctrl.async_load_n && !count_edge)
            |=> !zero_flag_n || ctrl.count_enable_n
    ) else $error("zero flag released without a count clock edge");

    edge_single_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        count_edge |=> !count_edge
    ) else $error("count clock edge pulse lasted more than one cycle");

    // The next three check that every pin reaches the decode two clk cycles late.
    edge_latency_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        count_edge == ($past(count_clock, 2) && !$past(count_clock, 3))
    ) else $error("count clock edge seen at the wrong cycle");

    ctrl_sync_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ctrl == $past(ctrl_pins, 2)
    ) else $error("control pins not seen two cycles after sampling");

    preset_sync_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        preset_s == $past(preset_value, 2)
    ) else $error("preset word not seen two cycles after sampling");

    async_over_sync_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ctrl.max_reset_n && !ctrl.async_load_n && !ctrl.sync_load_n && count_edge)
            |=> count_q == $past(preset_s)
    ) else $error("sync load won against async load");

    clear_hold_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!ctrl.max_reset_n)[*2] |-> count_q == `CNT_MAX
    ) else $error("count left maximum while clear held");

    // ****************************************************************
    // Covers
    // ****************************************************************

    reach_zero_c: cover property (
        @(posedge clk) disable iff (!reset_n)
        (run_s and (count_edge && count_q == `CNT_ONE && !ctrl.count_enable_n))
            ##1 !zero_flag_n
    );

    wrap_c: cover property (
        @(posedge clk) disable iff (!reset_n)
        count_q == `CNT_ZERO ##1 count_q == `CNT_MAX
    );

    sync_load_c: cover property (
        @(posedge clk) disable iff (!reset_n)
        action == ACT_SYNC_LOAD
    );

    async_load_c: cover property (
        @(posedge clk) disable iff (!reset_n)
        action == ACT_ASYNC_LOAD ##1 action == ACT_ASYNC_LOAD
    );

    clear_c: cover property (
        @(posedge clk) disable iff (!reset_n)
        action == ACT_CLEAR ##1 action == ACT_HOLD
    );

endmodule

// ==== test/count_clock_board.sv ====
/*
 * Board-side model that makes pulses on the count clock pin.
 * Assumes the caller enters pulse just after a rising clk edge.
 */
module count_clock_board (
    input  wire logic clk,
    output logic      count_clock
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        count_clock = 1'b0;
    end

    // One common count clock for every stage; high and low phases last at least
    // three clk cycles so the pin synchroniser never drops an edge.
    task automatic pulse();
        @(posedge clk);
        #1 count_clock = 1'b1;
        repeat (3) @(posedge clk);
        #1 count_clock = 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule

// ==== test/preset_down_counter_bench.sv ====
/*
 * Self-checking bench for the preset down counter and a chained second stage.
 * Assumes the board model makes one count clock pulse every 7 clk cycles.
 */
module preset_down_counter_bench
    import down_counter_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PULSE_CYCLES = 7;

    logic   clk;
    logic   reset_n;
    logic   count_clock;
    ctrl_s  ctrl;
    count_t preset;
    logic   zero_flag_n;
    count_t count_value;
    logic   chain_flag_n;
    count_t chain_value;
    int     mismatches;
    int     checks_done;
    int     low_cycles;
    int     cycle_cnt;

    ctrl_s  tbl_c [5] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h0};
    count_t tbl_e [5] = '{8'h10, 8'h0f, 8'ha5, 8'ha5, 8'hff};

    // ****************************************************************
    // Design, chained stage and board model
    // ****************************************************************
    preset_down_counter dut_u (
        .clk            (clk),
        .reset_n        (reset_n),
        .count_clock    (count_clock),
        .count_enable_n (ctrl.count_enable_n),
        .sync_load_n    (ctrl.sync_load_n),
        .async_load_n   (ctrl.async_load_n),
        .max_reset_n    (ctrl.max_reset_n),
        .preset_value   (preset),
        .zero_flag_n    (zero_flag_n),
        .count_value    (count_value)
    );

    // The second stage counts once for each wrap of the first.
    preset_down_counter chain_u (
        .clk            (clk),
        .reset_n        (reset_n),
        .count_clock    (count_clock),
        .count_enable_n (zero_flag_n),
        .sync_load_n    (1'b1),
        .async_load_n   (1'b1),
        .max_reset_n    (ctrl.max_reset_n),
        .preset_value   (preset),
        .zero_flag_n    (chain_flag_n),
        .count_value    (chain_value)
    );

    count_clock_board board_u (
        .clk         (clk),
        .count_clock (count_clock)
    );

    // ****************************************************************
    // Clock, timeout and helpers
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (zero_flag_n === 1'b0) begin
            low_cycles++;
        end
    end

    always @(posedge clk) begin
        cycle_cnt++;
        if (cycle_cnt == 2000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        // Look a little after the edge, once the flops have taken their new values.
        #2;
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic drive(input ctrl_s c, input count_t p);
        @(posedge clk);
        #1;
        ctrl = c;
        preset = p;
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        reset_n = 1'b0;
        ctrl = 4'hf;
        preset = 8'h00;
        mismatches = 0;
        checks_done = 0;
        low_cycles = 0;
        cycle_cnt = 0;
        repeat (8) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk);
        check(count_value, 8'hff, "reset value");
        check({7'h00, zero_flag_n}, 8'h01, "flag idle");
        // Hold, count, sync load, async load and clear, each from a base of 0x10.
        for (int i = 0; i < 5; i++) begin
            drive(4'hb, 8'h10);
            repeat (4) @(posedge clk);
            check(count_value, 8'h10, "async base");
            drive(tbl_c[i], 8'ha5);
            board_u.pulse();
            drive(4'hf, 8'ha5);
            repeat (4) @(posedge clk);
            check(count_value, tbl_e[i], "precedence");
        end
        drive(4'hb, 8'h02);
        repeat (4) @(posedge clk);
        drive(4'he, 8'h02);
        board_u.pulse();
        check(count_value, 8'h01, "count to one");
        check({7'h00, zero_flag_n}, 8'h01, "flag at one");
        low_cycles = 0;
        board_u.pulse();
        check(count_value, 8'h00, "count to zero");
        check({7'h00, zero_flag_n}, 8'h00, "flag at zero");
        board_u.pulse();
        check(count_value, 8'hff, "wrap");
        check(low_cycles[7:0], PULSE_CYCLES[7:0], "flag low width");
        check(chain_value, 8'hfe, "chained stage");
        check({7'h00, chain_flag_n}, 8'h01, "chained flag");
        drive(4'ha, 8'h00);
        repeat (4) @(posedge clk);
        check({7'h00, zero_flag_n}, 8'h00, "flag after async load");
        drive(4'hf, 8'h00);
        repeat (4) @(posedge clk);
        check({7'h00, zero_flag_n}, 8'h01, "flag disabled");
        board_u.pulse();
        check(count_value, 8'h00, "hold at zero");
        test_done();
    end
endmodule
